// >>> design/emb_bus_port.sv
// Purpose: External memory and I/O bus port: address, data, strobes, chip selects, bus hand-over
// Assumes: CPU holds its request stable until done; pins pass a three-stage synchroniser
// Notes:   Two-way pins split into in, out and active-low output enable
// How it works
// - Drive address as output in normal operation
// - Release address, sample as input when granted
// - Address feeds chip select decoder
// - Four active-low selects, low inside their range
// - Drive data only on own write cycles
// - I/O request low on I/O access
// - Memory request low on memory access
// - Requests undriven in reset, inputs when granted
// - Read strobe low while reading
// - Write strobe low while writing
// - Read and write strobes float when granted
// - Wait low stretches the strobe phase
`timescale 1ns/100ps
module emb_bus_port #(
  parameter logic [emb_pkg::NUM_CS-1:0][emb_pkg::ADDR_W-1:0] CS_BASE = {24'h030000, 24'h020000, 24'h010000, 24'h000000},
  parameter logic [emb_pkg::NUM_CS-1:0][emb_pkg::ADDR_W-1:0] CS_MASK = {24'hFF0000, 24'hFF0000, 24'hFF0000, 24'hFF0000},
  parameter logic [emb_pkg::NUM_CS-1:0]                      CS_IO   = 4'h8,
  parameter logic [emb_pkg::CNT_W-1:0]                       STROBE_CYCLES = emb_pkg::STROBE_MIN
) (
  // Clock and reset
  input  wire  logic                            clk_in,
  input  wire  logic                            sys_rst_in,
  // CPU side
  input  wire  logic                            cpu_req_in,
  input  wire  emb_pkg::emb_cpu_req_type        cpu_cmd_in,
  output logic                                  cpu_done_out,
  output logic [emb_pkg::DATA_W-1:0]            cpu_rdata_out,
  output logic                                  cpu_granted_out,
  output logic [emb_pkg::ADDR_W-1:0]            ext_addr_out,
  output logic                                  ext_mem_request_n_out,
  output logic                                  ext_io_request_n_out,
  // Address pins
  input  wire  logic [emb_pkg::ADDR_W-1:0]      addr_in,
  output logic [emb_pkg::ADDR_W-1:0]            addr_out,
  output logic [emb_pkg::ADDR_W-1:0]            addr_oe_n_out,
  // Data pins
  input  wire  logic [emb_pkg::DATA_W-1:0]      data_in,
  output logic [emb_pkg::DATA_W-1:0]            data_out,
  output logic [emb_pkg::DATA_W-1:0]            data_oe_n_out,
  // Request pins
  input  wire  logic                            mem_request_n_in,
  output logic                                  mem_request_n_out,
  output logic                                  mem_request_oe_n_out,
  input  wire  logic                            io_request_n_in,
  output logic                                  io_request_n_out,
  output logic                                  io_request_oe_n_out,
  // Strobes
  output logic                                  read_n_out,
  output logic                                  read_oe_n_out,
  output logic                                  write_n_out,
  output logic                                  write_oe_n_out,
  output logic                                  instr_fetch_n_out,
  output logic                                  instr_fetch_oe_n_out,
  // Chip selects
  output logic                                  chip_sel_0_n_out,
  output logic                                  chip_sel_1_n_out,
  output logic                                  chip_sel_2_n_out,
  output logic                                  chip_sel_3_n_out,
  // Handshakes
  input  wire  logic                            wait_n_in,
  input  wire  logic                            bus_request_n_in,
  output logic                                  bus_grant_n_out
);
  import emb_pkg::*;

  // Pin synchroniser: change counts once stages two and three agree
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [PIN_W-1:0] pin_filt;
  logic [PIN_W-1:0] next_pin_filt;
  emb_pin_in_type   pin_f;
  emb_pin_in_type   pin_raw;

  assign pin_raw = '{bus_request_n: bus_request_n_in, wait_n: wait_n_in, mem_request_n: mem_request_n_in,
                     io_request_n: io_request_n_in, data: data_in, addr: addr_in};
  assign pin_f   = pin_filt;

  always_comb begin
    next_pin_filt = (pin_s2 & pin_s3) | (pin_filt & (pin_s2 ^ pin_s3));
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_s1   <= PIN_RESET;
      pin_s2   <= PIN_RESET;
      pin_s3   <= PIN_RESET;
      pin_filt <= PIN_RESET;
    end else begin
      pin_s1   <= pin_raw;
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin_filt <= next_pin_filt;
    end
  end

  // Chip select decode, own access or external master
  emb_state_type     state;
  emb_state_type     next_state;
  emb_cpu_req_type   req;
  emb_cpu_req_type   next_req;
  logic [ADDR_W-1:0] dec_addr;
  logic              dec_io;
  logic [NUM_CS-1:0] hit;
  logic [NUM_CS-1:0] sel;

  always_comb begin
    if (next_state == ST_GRANT) begin
      dec_addr = pin_f.addr;
      dec_io   = ~pin_f.io_request_n;
    end else begin
      dec_addr = next_req.addr;
      dec_io   = next_req.io;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CS; gi++) begin : g_hit
      assign hit[gi] = ((dec_addr & CS_MASK[gi]) == CS_BASE[gi]) && (dec_io == CS_IO[gi]);
    end
  endgenerate

  always_comb begin
    sel = '0;
    for (int i = NUM_CS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        sel = '0;
        sel[i] = 1'b1;
      end
    end
  end

  // Bus cycle sequencer and pin registers
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic              done;
  logic              next_done;
  logic              drive;
  logic              next_drive;
  logic              grant_n;
  logic              next_grant_n;
  logic              mem_request_n_n;
  logic              next_mem_request_n_n;
  logic              io_request_n_n;
  logic              next_io_request_n_n;
  logic              rd_n;
  logic              next_rd_n;
  logic              wr_n;
  logic              next_wr_n;
  logic              ifetch_n;
  logic              next_ifetch_n;
  logic              data_oe_n;
  logic              next_data_oe_n;
  logic [ADDR_W-1:0] addr_o;
  logic [ADDR_W-1:0] next_addr_o;
  logic [NUM_CS-1:0] cs_n;
  logic [NUM_CS-1:0] next_cs_n;
  logic              in_cycle;

  always_comb begin
    next_state = state;
    next_req   = req;
    next_cnt   = cnt;
    next_rdata = rdata;
    next_done  = 1'b0;
    case (state)
      ST_IDLE: begin
        if (!pin_f.bus_request_n) begin
          next_state = ST_GRANT;
        end else if (cpu_req_in) begin
          next_req   = cpu_cmd_in;
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_cnt   = CNT_ZERO;
        next_state = ST_STROBE;
      end
      ST_STROBE: begin
        if (cnt != STROBE_CYCLES - CNT_ONE) begin
          next_cnt = cnt + CNT_ONE;
        end else if (pin_f.wait_n) begin
          next_state = ST_END;
          next_done  = 1'b1;
          if (!req.write) begin
            next_rdata = pin_f.data;
          end
        end
      end
      ST_END: begin
        next_state = ST_IDLE;
      end
      ST_GRANT: begin
        if (pin_f.bus_request_n) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    in_cycle       = (next_state == ST_SETUP) || (next_state == ST_STROBE);
    next_drive     = (next_state != ST_GRANT);
    next_grant_n   = (next_state != ST_GRANT);
    next_addr_o    = (next_state == ST_GRANT) ? addr_o : next_req.addr;
    next_mem_request_n_n    = ~(in_cycle && !next_req.io);
    next_io_request_n_n    = ~(in_cycle && next_req.io);
    next_ifetch_n  = ~(in_cycle && !next_req.io && next_req.fetch);
    next_rd_n      = ~((next_state == ST_STROBE) && !next_req.write);
    next_wr_n      = ~((next_state == ST_STROBE) && next_req.write);
    next_data_oe_n = ~((in_cycle || next_state == ST_END) && next_req.write);
    if (in_cycle) begin
      next_cs_n = ~sel;
    end else if (next_state == ST_GRANT && !(pin_f.mem_request_n && pin_f.io_request_n)) begin
      next_cs_n = ~sel;
    end else begin
      next_cs_n = CS_IDLE;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state     <= ST_IDLE;
      req       <= REQ_RESET;
      cnt       <= CNT_ZERO;
      rdata     <= DATA_ZERO;
      done      <= 1'b0;
      drive     <= 1'b0;
      grant_n   <= 1'b1;
      addr_o    <= ADDR_ZERO;
      mem_request_n_n    <= 1'b1;
      io_request_n_n    <= 1'b1;
      ifetch_n  <= 1'b1;
      rd_n      <= 1'b1;
      wr_n      <= 1'b1;
      data_oe_n <= 1'b1;
      cs_n      <= CS_IDLE;
    end else begin
      state     <= next_state;
      req       <= next_req;
      cnt       <= next_cnt;
      rdata     <= next_rdata;
      done      <= next_done;
      drive     <= next_drive;
      grant_n   <= next_grant_n;
      addr_o    <= next_addr_o;
      mem_request_n_n    <= next_mem_request_n_n;
      io_request_n_n    <= next_io_request_n_n;
      ifetch_n  <= next_ifetch_n;
      rd_n      <= next_rd_n;
      wr_n      <= next_wr_n;
      data_oe_n <= next_data_oe_n;
      cs_n      <= next_cs_n;
    end
  end

  assign cpu_done_out          = done;
  assign cpu_rdata_out         = rdata;
  assign cpu_granted_out       = ~grant_n;
  assign bus_grant_n_out       = grant_n;
  assign ext_addr_out          = pin_f.addr;
  assign ext_mem_request_n_out = pin_f.mem_request_n;
  assign ext_io_request_n_out  = pin_f.io_request_n;
  assign addr_out              = addr_o;
  assign addr_oe_n_out         = {ADDR_W{~drive}};
  assign data_out              = req.wdata;
  assign data_oe_n_out         = {DATA_W{data_oe_n}};
  assign mem_request_n_out     = mem_request_n_n;
  assign mem_request_oe_n_out  = ~drive;
  assign io_request_n_out      = io_request_n_n;
  assign io_request_oe_n_out   = ~drive;
  assign read_n_out            = rd_n;
  assign read_oe_n_out         = ~drive;
  assign write_n_out           = wr_n;
  assign write_oe_n_out        = ~drive;
  assign instr_fetch_n_out     = ifetch_n;
  assign instr_fetch_oe_n_out  = ~drive;
  assign chip_sel_0_n_out      = cs_n[0];
  assign chip_sel_1_n_out      = cs_n[1];
  assign chip_sel_2_n_out      = cs_n[2];
  assign chip_sel_3_n_out      = cs_n[3];

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  addr_normal_drive_a: assert property ((state != ST_GRANT && !$past(sys_rst_in))
    |-> (addr_oe_n_out == ADDR_ZERO))
    else $error("address not driven outside grant");
  addr_grant_release_a: assert property ((state == ST_GRANT) |-> (addr_oe_n_out == ADDR_FLOAT))
    else $error("address driven during grant");
  grant_follows_request_a: assert property ((state == ST_IDLE && !pin_f.bus_request_n) |=> !bus_grant_n_out)
    else $error("grant not given from idle");
  cs_decode_match_a: assert property ((state == ST_STROBE) |-> (cs_n == ~sel))
    else $error("chip select differs from decode");
  cs_only_access_a: assert property ((cs_n != CS_IDLE) |-> (state inside {ST_SETUP, ST_STROBE, ST_GRANT}))
    else $error("chip select low outside access");
  cs_single_low_a: assert property ($countones(~cs_n) <= 1)
    else $error("more than one chip select low");
  data_write_only_a: assert property ((data_oe_n_out != DATA_FLOAT) |-> (req.write && state != ST_GRANT))
    else $error("data driven outside own write");
  io_request_cycle_a: assert property ((state == ST_SETUP && req.io) |-> (!io_request_n_out && mem_request_n_out))
    else $error("io request wrong on io access");
  mem_request_cycle_a: assert property ((state == ST_SETUP && !req.io) |=> (!mem_request_n_out && io_request_n_out))
    else $error("memory request wrong on memory access");
  req_grant_float_a: assert property ((state == ST_GRANT) |-> (mem_request_oe_n_out && io_request_oe_n_out))
    else $error("requests driven during grant");
  read_strobe_a: assert property ((state == ST_STROBE && !req.write) |-> (!read_n_out && write_n_out))
    else $error("read strobe wrong");
  write_strobe_a: assert property ((state == ST_STROBE && req.write) |-> (!write_n_out && read_n_out))
    else $error("write strobe wrong");
  strobe_float_a: assert property ((state == ST_GRANT) |-> (read_oe_n_out && write_oe_n_out))
    else $error("strobes driven during grant");
  wait_stretch_a: assert property ((state == ST_STROBE && !pin_f.wait_n) |=> (state == ST_STROBE))
    else $error("strobe ended while wait held");
  strobe_length_a: assert property ($rose(state == ST_STROBE) |-> (state == ST_STROBE)[*4])
    else $error("strobe shorter than four cycles");

endmodule

// >>> design/emb_pkg.sv
// Purpose: Shared types and constants for the external memory and I/O bus port
// Assumes: 24-bit address bus, 8-bit data bus, four chip selects
// Notes:   Pin input bundle travels as one packed struct through the synchroniser
package emb_pkg;

  localparam int ADDR_W  = 24;
  localparam int DATA_W  = 8;
  localparam int NUM_CS  = 4;
  localparam int CNT_W   = 4;

  localparam logic [ADDR_W-1:0] ADDR_ZERO   = 24'h000000;
  localparam logic [ADDR_W-1:0] ADDR_FLOAT  = 24'hFFFFFF;
  localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;
  localparam logic [DATA_W-1:0] DATA_FLOAT  = 8'hFF;
  localparam logic [NUM_CS-1:0] CS_IDLE     = 4'hF;
  localparam logic [CNT_W-1:0]  CNT_ZERO    = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE     = 4'h1;
  localparam logic [CNT_W-1:0]  STROBE_MIN  = 4'h4;

  // Request from the CPU core side
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              write;
    logic              io;
    logic              fetch;
  } emb_cpu_req_type;

  localparam emb_cpu_req_type REQ_RESET = '{addr: ADDR_ZERO, wdata: DATA_ZERO, write: 1'b0, io: 1'b0, fetch: 1'b0};

  // Levels sampled from the pins
  typedef struct packed {
    logic              bus_request_n;
    logic              wait_n;
    logic              mem_request_n;
    logic              io_request_n;
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] addr;
  } emb_pin_in_type;

  localparam int PIN_W = $bits(emb_pin_in_type);
  localparam logic [PIN_W-1:0] PIN_RESET = {PIN_W{1'b1}};

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_SETUP  = 5'h02,
    ST_STROBE = 5'h04,
    ST_END    = 5'h08,
    ST_GRANT  = 5'h10
  } emb_state_type;

endpackage

// >>> dv/emb_far_model.sv
// Purpose: Far-side model: external memory, peripheral and alternate bus master
// Assumes: Testbench resolves the shared pins and feeds the levels back here
// Notes:   Wait and mastership are commanded by the testbench
`timescale 1ns/100ps
module emb_far_model (
  // Clock
  input  wire logic        clk_in,
  // Resolved pin levels
  input  wire logic [23:0] addr_in,
  input  wire logic [7:0]  data_in,
  input  wire logic        read_n_in,
  input  wire logic        write_n_in,
  input  wire logic        req_n_in,
  input  wire logic        bus_grant_n_in,
  // Commands from the testbench
  input  wire logic        slow_in,
  input  wire logic        master_in,
  // Far-side drivers
  output logic [7:0]       data_out,
  output logic             data_drive_out,
  output logic             wait_n_out,
  output logic             bus_request_n_out,
  output logic             master_drive_out
);
  logic [7:0] mem [64];
  logic [3:0] wait_cnt = 4'h0;
  logic [5:0] key;

  assign key = {addr_in[17:16], addr_in[3:0]};
  // Drive for the whole read so data clears the pin synchroniser
  assign data_drive_out = !req_n_in && write_n_in && bus_grant_n_in;
  assign data_out = mem[key];
  // Slow device stretches every access
  assign wait_n_out = !(slow_in && !req_n_in && wait_cnt < 4'h6);
  assign bus_request_n_out = !master_in;
  assign master_drive_out = master_in && !bus_grant_n_in;

  always_ff @(posedge clk_in) begin
    wait_cnt <= req_n_in ? 4'h0 : wait_cnt + 4'h1;
    if (!write_n_in && bus_grant_n_in) begin
      mem[key] <= data_in;
    end
  end
endmodule

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the external memory and I/O bus port
// Assumes: Pull-ups on control lines; released address and data show inverse of last level
// Notes:   Default chip select map and strobe length
`timescale 1ns/100ps
module testbench;
  import emb_pkg::*;
  logic                  clk_in, sys_rst_in, cpu_req_in, cpu_done_out, cpu_granted_out;
  emb_cpu_req_type       cpu_cmd_in;
  logic [7:0]            cpu_rdata_out, data_in, data_out, data_oe_n_out, m_data;
  logic [23:0]           ext_addr_out, addr_in, addr_out, addr_oe_n_out, m_addr;
  logic                  ext_mem_request_n_out, ext_io_request_n_out, bus_grant_n_out;
  logic                  mem_request_n_in, mem_request_n_out, mem_request_oe_n_out;
  logic                  io_request_n_in, io_request_n_out, io_request_oe_n_out;
  logic                  read_n_out, read_oe_n_out, write_n_out, write_oe_n_out;
  logic                  instr_fetch_n_out, instr_fetch_oe_n_out, wait_n_in, bus_request_n_in;
  logic                  chip_sel_0_n_out, chip_sel_1_n_out, chip_sel_2_n_out, chip_sel_3_n_out;
  logic                  rd_n, wr_n, req_n, slow, master, m_drv, d_drv;
  logic [23:0]           last_a = 24'h000000;
  logic [7:0]            last_d = 8'h00;
  int                    n_fail = 0;
  int                    checks_done = 0;

  // Wire resolution across all drivers
  assign addr_in = (~addr_oe_n_out & addr_out) | (addr_oe_n_out & (m_drv ? m_addr : ~last_a));
  assign data_in = (~data_oe_n_out & data_out) | (data_oe_n_out & (d_drv ? m_data : ~last_d));
  assign mem_request_n_in = mem_request_oe_n_out ? !m_drv : mem_request_n_out;
  assign io_request_n_in = io_request_oe_n_out ? 1'b1 : io_request_n_out;
  assign rd_n = read_oe_n_out | read_n_out;
  assign wr_n = write_oe_n_out | write_n_out;
  assign req_n = mem_request_n_in & io_request_n_in;

  always @(posedge clk_in) begin
    last_a <= addr_in;
    last_d <= data_in;
  end

  emb_bus_port dut (.clk_in, .sys_rst_in, .cpu_req_in, .cpu_cmd_in, .cpu_done_out, .cpu_rdata_out,
    .cpu_granted_out, .ext_addr_out, .ext_mem_request_n_out, .ext_io_request_n_out, .addr_in, .addr_out,
    .addr_oe_n_out, .data_in, .data_out, .data_oe_n_out, .mem_request_n_in, .mem_request_n_out,
    .mem_request_oe_n_out, .io_request_n_in, .io_request_n_out, .io_request_oe_n_out, .read_n_out,
    .read_oe_n_out, .write_n_out, .write_oe_n_out, .instr_fetch_n_out, .instr_fetch_oe_n_out,
    .chip_sel_0_n_out, .chip_sel_1_n_out, .chip_sel_2_n_out, .chip_sel_3_n_out, .wait_n_in,
    .bus_request_n_in, .bus_grant_n_out);

  emb_far_model far (.clk_in, .addr_in, .data_in, .read_n_in(rd_n), .write_n_in(wr_n), .req_n_in(req_n),
    .bus_grant_n_in(bus_grant_n_out), .slow_in(slow), .master_in(master), .data_out(m_data),
    .data_drive_out(d_drv), .wait_n_out(wait_n_in), .bus_request_n_out(bus_request_n_in),
    .master_drive_out(m_drv));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [3:0] exp_cs(input logic [23:0] a, input logic io);
    if (a[23:18] != 6'h00 || io != (a[17:16] == 2'h3)) return 4'hF;
    return ~(4'h1 << a[17:16]);
  endfunction

  task automatic access(input logic [23:0] a, input logic [7:0] d, input logic wr, io, fe, slow_c,
                        output logic [7:0] rd);
    int         n;
    logic       seen;
    logic [3:0] cs;
    n = 0;
    seen = 1'b0;
    @(posedge clk_in);
    cpu_req_in <= 1'b1;
    cpu_cmd_in <= '{addr: a, wdata: d, write: wr, io: io, fetch: fe};
    slow <= slow_c;
    while (cpu_done_out !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1;
      n++;
      if (!seen && (read_n_out === 1'b0 || write_n_out === 1'b0)) begin
        seen = 1'b1;
        cs = {chip_sel_3_n_out, chip_sel_2_n_out, chip_sel_1_n_out, chip_sel_0_n_out};
        check("addr", {addr_oe_n_out, addr_out}, {24'h000000, a});
        check("sel", cs, exp_cs(a, io));
        check("one sel", $countones(~cs) <= 1, 1'b1);
        check("req", {mem_request_n_out, io_request_n_out}, {io, !io});
        check("strobe", {read_n_out, write_n_out, instr_fetch_n_out}, {wr, !wr, !fe});
        check("data", {data_oe_n_out, data_out & {8{wr}}}, {wr ? 8'h00 : 8'hFF, d & {8{wr}}});
      end
    end
    check("seen", seen, 1'b1);
    if (slow_c) begin
      check("stretch", n > 7, 1'b1);
    end else begin
      check("cycles", n, int'(STROBE_MIN) + 2);
    end
    rd = cpu_rdata_out;
    @(posedge clk_in);
    cpu_req_in <= 1'b0;
    slow <= 1'b0;
  endtask

  task automatic test_reset();
    repeat (19) @(posedge clk_in);
    #1;
    check("addr float", addr_oe_n_out, 24'hFFFFFF);
    check("grant idle", {bus_grant_n_out, cpu_granted_out}, 2'b10);
    check("req float", {mem_request_oe_n_out, io_request_oe_n_out}, 2'h3);
    check("data float", data_oe_n_out, 8'hFF);
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    check("addr driven", addr_oe_n_out, 24'h000000);
    check("req driven", {mem_request_oe_n_out, io_request_oe_n_out, bus_grant_n_out}, 3'h1);
    repeat (6) @(posedge clk_in);
    $display("test_reset done");
  endtask

  task automatic test_access();
    logic [26:0] tab [7] = '{{24'h000012, 3'b000}, {24'h010023, 3'b001}, {24'h020034, 3'b010},
                             {24'h030045, 3'b100}, {24'h030056, 3'b000}, {24'h010007, 3'b100},
                             {24'h040008, 3'b001}};
    logic [7:0]  rd;
    for (int i = 0; i < 7; i++) begin
      access(tab[i][26:3], {i[3:0], 4'hC}, 1'b1, tab[i][2], 1'b0, tab[i][0], rd);
      access(tab[i][26:3], 8'h00, 1'b0, tab[i][2], tab[i][1], tab[i][0], rd);
      check("read back", rd, {i[3:0], 4'hC});
    end
    $display("test_access done");
  endtask

  task automatic test_grant();
    int   n;
    logic early;
    n = 0;
    early = 1'b0;
    @(posedge clk_in);
    master <= 1'b1;
    while (bus_grant_n_out !== 1'b0 && n < 20) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    repeat (6) @(posedge clk_in);
    #1;
    check("addr input", addr_oe_n_out, 24'hFFFFFF);
    check("req input", {mem_request_oe_n_out, io_request_oe_n_out}, 2'h3);
    check("strobe float", {read_oe_n_out, write_oe_n_out, data_oe_n_out}, 10'h3FF);
    check("fetch float", instr_fetch_oe_n_out, 1'b1);
    check("ext io", ext_io_request_n_out, 1'b1);
    check("ext addr", {ext_addr_out, ext_mem_request_n_out, cpu_granted_out}, {24'h020010, 2'b01});
    check("ext sel", chip_sel_2_n_out, 1'b0);
    @(posedge clk_in);
    cpu_req_in <= 1'b1;
    cpu_cmd_in <= '{addr: 24'h000012, wdata: 8'h00, write: 1'b0, io: 1'b0, fetch: 1'b0};
    repeat (10) begin
      @(posedge clk_in);
      #1;
      early = early | (cpu_done_out === 1'b1);
    end
    check("refused", early, 1'b0);
    @(posedge clk_in);
    master <= 1'b0;
    n = 0;
    while (cpu_done_out !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check("late read", {cpu_done_out, cpu_rdata_out, bus_grant_n_out}, {1'b1, 8'h0C, 1'b1});
    check("addr back", addr_oe_n_out, 24'h000000);
    @(posedge clk_in);
    cpu_req_in <= 1'b0;
    $display("test_grant done");
  endtask

  initial begin
    repeat (5000) @(posedge clk_in);
    n_fail++;
    finish_test();
  end

  initial begin
    sys_rst_in = 1'b1;
    cpu_req_in = 1'b0;
    cpu_cmd_in = REQ_RESET;
    slow = 1'b0;
    master = 1'b0;
    m_addr = 24'h020010;
    test_reset();
    test_access();
    test_grant();
    finish_test();
  end
endmodule
